//--- rtl/wide_addr_cfg.svh
`ifndef WIDE_ADDR_CFG_SVH
`define WIDE_ADDR_CFG_SVH
// status register bit positions
`define SR_CARRY_BIT       0
`define SR_ZERO_BIT        1
`define SR_NEG_BIT         2
`define SR_GIE_BIT         3
`define SR_CORE_OFF_BIT_BIT      4
`define SR_OSCILLATOR_OFF_BIT_BIT      5
`define SR_OVF_BIT         8
// register indices
`define REG_PC             4'h0
`define REG_SP             4'h1
`define REG_SR             4'h2
// step constants
`define WORD_STEP          20'h00002
`define PTR_STEP           20'h00004
`define HIGH_WORD_OFS      20'h00002
// reset values
`define PC_RESET           20'h00000
`define SP_RESET           20'h00000
`define SR_RESET           16'h0000
// apb register byte offsets
`define OFS_CTRL           12'h000
`define OFS_INSTR          12'h004
`define OFS_SRC            12'h008
`define OFS_INDEX          12'h00C
`define OFS_STATUS         12'h010
`define OFS_SR             12'h014
`define OFS_PC             12'h018
`define OFS_SP             12'h01C
`define OFS_REG_BASE       12'h040
`define OFS_REG_LAST       12'h07C
`endif

//--- rtl/wide_addr_pkg.sv
`default_nettype none
package wide_addr_pkg;
   typedef enum logic [3:0] {
      OP_MOVE_WIDE,
      OP_ADD_ADDRESS_WORD,
      OP_SUBTRACT_WIDE,
      OP_COMPARE_WIDE,
      OP_CALL_FAR,
      OP_RETURN_FAR
   } op_t;

   typedef enum logic [2:0] {
      AM_REGISTER,
      AM_IMMEDIATE,
      AM_INDEXED,
      AM_SYMBOLIC,
      AM_ABSOLUTE,
      AM_INDIRECT,
      AM_INDIRECT_INC
   } mode_t;

   typedef struct packed {
      op_t        op;
      mode_t      mode;
      logic [3:0] src_reg;
      logic [3:0] dst_reg;
   } instr_t;

   typedef struct packed {
      logic        req;
      logic        we;
      logic [19:0] addr;
      logic [15:0] wdata;
   } mem_req_t;
endpackage : wide_addr_pkg
`default_nettype wire

//--- rtl/wide_address_instruction_unit.sv
`timescale 1ns/1ps
`include "wide_addr_cfg.svh"
`default_nettype none
module wide_address_instruction_unit #(
   parameter int NUM_REGS = 16
) (
   input  wire  logic        sys_clk,
   input  wire  logic        reset_n,
   input  wire  logic        psel,
   input  wire  logic        penable,
   input  wire  logic        pwrite,
   input  wire  logic [11:0] paddr,
   input  wire  logic [31:0] pwdata,
   output logic        [31:0] prdata,
   output logic              pready,
   output logic              pslverr,
   output wide_addr_pkg::mem_req_t mem_req,
   input  wire  logic        mem_ack,
   input  wire  logic [15:0] mem_rdata
);
   typedef enum {
      ST_IDLE,
      ST_RD_LO,
      ST_RD_HI,
      ST_PUSH_HI,
      ST_PUSH_LO,
      ST_POP_LO,
      ST_POP_HI,
      ST_DONE
   } state_t;

   state_t                 state;
   wide_addr_pkg::instr_t  instr;
   logic [19:0]            regs [NUM_REGS];
   logic [15:0]            sr;
   logic [19:0]            src_imm;
   logic [15:0]            index;
   logic [19:0]            tmp;
   logic [19:0]            addr;
   logic                   busy;
   logic                   mode_err;
   logic                   wr_acc;
   logic                   start;
   logic [19:0]            src_val;
   logic [19:0]            dst_val;
   logic [20:0]            sum;
   logic [19:0]            res;
   logic                   ovf;
   logic                   reg_mode;
   logic [19:0]            ea;
   logic [19:0]            ret_pc;

   assign pready  = 1'b1;
   assign wr_acc  = psel & penable & pwrite;
   assign start   = wr_acc && paddr == `OFS_CTRL && pwdata[0] && !busy;
   assign pslverr = 1'b0;

   // decode: one instruction word, no prefix
   assign reg_mode = instr.mode == wide_addr_pkg::AM_REGISTER || instr.mode == wide_addr_pkg::AM_IMMEDIATE;
   assign src_val  = instr.mode == wide_addr_pkg::AM_IMMEDIATE ? src_imm : regs[instr.src_reg];
   assign dst_val  = regs[instr.dst_reg];
   assign ret_pc   = regs[`REG_PC];

   // effective address of a memory-held target
   always_comb
   begin
      unique case (instr.mode)
         wide_addr_pkg::AM_INDEXED:  ea = regs[instr.src_reg] + {{4{index[15]}}, index};
         wide_addr_pkg::AM_SYMBOLIC: ea = regs[`REG_PC] + {{4{index[15]}}, index};
         wide_addr_pkg::AM_ABSOLUTE: ea = src_imm;
         wide_addr_pkg::AM_INDIRECT, wide_addr_pkg::AM_INDIRECT_INC: ea = regs[instr.src_reg];
         default:                    ea = regs[instr.src_reg];
      endcase
   end

   // shared 20-bit adder: add or add inverted plus one
   always_comb
   begin
      if (instr.op == wide_addr_pkg::OP_ADD_ADDRESS_WORD)
      begin
         sum = {1'b0, dst_val} + {1'b0, src_val};
         ovf = (src_val[19] == dst_val[19]) && (sum[19] != dst_val[19]);
      end
      else
      begin
         sum = {1'b0, dst_val} + {1'b0, ~src_val} + 21'h000001;
         ovf = (src_val[19] != dst_val[19]) && (sum[19] != dst_val[19]);
      end
      res = sum[19:0];
   end

   // mode check: address-word group limited to register/immediate
   assign mode_err = !reg_mode &&
                     (instr.op == wide_addr_pkg::OP_ADD_ADDRESS_WORD ||
                      instr.op == wide_addr_pkg::OP_SUBTRACT_WIDE ||
                      instr.op == wide_addr_pkg::OP_COMPARE_WIDE);

   // sequencer
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state <= ST_IDLE;
      end
      else
      begin
         unique case (state)
            ST_IDLE:
               if (start)
               begin
                  if (mode_err)
                     state <= ST_DONE;
                  else if (instr.op == wide_addr_pkg::OP_RETURN_FAR)
                     state <= ST_POP_LO;
                  else if ((instr.op == wide_addr_pkg::OP_MOVE_WIDE || instr.op == wide_addr_pkg::OP_CALL_FAR)
                           && !reg_mode)
                     state <= ST_RD_LO;
                  else if (instr.op == wide_addr_pkg::OP_CALL_FAR)
                     state <= ST_PUSH_HI;
                  else
                     state <= ST_DONE;
               end
            // each memory word waits for the partner's acknowledge
            ST_RD_LO:
               if (mem_ack)
                  state <= ST_RD_HI;
            ST_RD_HI:
               if (mem_ack)
                  state <= instr.op == wide_addr_pkg::OP_CALL_FAR ? ST_PUSH_HI : ST_DONE;
            ST_PUSH_HI:
               if (mem_ack)
                  state <= ST_PUSH_LO;
            ST_PUSH_LO:
               if (mem_ack)
                  state <= ST_DONE;
            ST_POP_LO:
               if (mem_ack)
                  state <= ST_POP_HI;
            ST_POP_HI:
               if (mem_ack)
                  state <= ST_DONE;
            ST_DONE:
               state <= ST_IDLE;
         endcase
      end
   end

   assign busy = state != ST_IDLE;

   // memory address and target temporary
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         addr <= 20'h00000;
         tmp  <= 20'h00000;
      end
      else if (state == ST_IDLE && start)
      begin
         addr <= ea;
         tmp  <= src_val;
      end
      else if (mem_ack)
      begin
         unique case (state)
            ST_RD_LO:
            begin
               tmp[15:0] <= mem_rdata;
               addr      <= addr + `HIGH_WORD_OFS;
            end
            ST_RD_HI:
               tmp[19:16] <= mem_rdata[3:0];
            default:    addr <= addr;
         endcase
      end
   end

   // memory request to the outside world
   always_comb
   begin
      mem_req.req   = 1'b0;
      mem_req.we    = 1'b0;
      mem_req.addr  = addr;
      mem_req.wdata = 16'h0000;
      unique case (state)
         ST_RD_LO, ST_RD_HI:
            mem_req.req = 1'b1;
         ST_PUSH_HI:
         begin
            mem_req.req   = 1'b1;
            mem_req.we    = 1'b1;
            mem_req.addr  = regs[`REG_SP] - `WORD_STEP;
            mem_req.wdata = {12'h000, ret_pc[19:16]};
         end
         ST_PUSH_LO:
         begin
            mem_req.req   = 1'b1;
            mem_req.we    = 1'b1;
            mem_req.addr  = regs[`REG_SP] - `WORD_STEP;
            mem_req.wdata = ret_pc[15:0];
         end
         ST_POP_LO, ST_POP_HI:
         begin
            mem_req.req  = 1'b1;
            mem_req.addr = regs[`REG_SP];
         end
         default:
            mem_req.req = 1'b0;
      endcase
   end

   // register file
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         for (int i = 0; i < NUM_REGS; i++)
            regs[i] <= 20'h00000;
      end
      else if (!busy && wr_acc && paddr >= `OFS_REG_BASE && paddr <= `OFS_REG_LAST)
      begin
         regs[paddr[5:2]] <= pwdata[19:0];
      end
      // host loads pc and sp directly through their own windows
      else if (!busy && wr_acc && paddr == `OFS_PC)
      begin
         regs[`REG_PC] <= pwdata[19:0];
      end
      else if (!busy && wr_acc && paddr == `OFS_SP)
      begin
         regs[`REG_SP] <= pwdata[19:0];
      end
      else
      begin
         unique case (state)
            ST_IDLE:
               if (start && !mode_err)
               begin
                  unique case (instr.op)
                     wide_addr_pkg::OP_ADD_ADDRESS_WORD, wide_addr_pkg::OP_SUBTRACT_WIDE:
                        regs[instr.dst_reg] <= res;
                     wide_addr_pkg::OP_MOVE_WIDE:
                        if (reg_mode)
                           regs[instr.dst_reg] <= src_val;
                     default:
                        regs[instr.dst_reg] <= regs[instr.dst_reg];
                  endcase
               end
            ST_RD_HI:
               if (mem_ack && instr.mode == wide_addr_pkg::AM_INDIRECT_INC)
                  regs[instr.src_reg] <= regs[instr.src_reg] + `PTR_STEP;
            ST_PUSH_HI, ST_PUSH_LO:
               if (mem_ack)
                  regs[`REG_SP] <= regs[`REG_SP] - `WORD_STEP;
            ST_POP_LO:
               if (mem_ack)
               begin
                  regs[`REG_PC][15:0] <= mem_rdata;
                  regs[`REG_SP]       <= regs[`REG_SP] + `WORD_STEP;
               end
            ST_POP_HI:
               if (mem_ack)
               begin
                  regs[`REG_PC][19:16] <= mem_rdata[3:0];
                  regs[`REG_SP]        <= regs[`REG_SP] + `WORD_STEP;
               end
            ST_DONE:
               if (instr.op == wide_addr_pkg::OP_CALL_FAR ||
                   (instr.op == wide_addr_pkg::OP_MOVE_WIDE && !reg_mode))
                  regs[instr.op == wide_addr_pkg::OP_CALL_FAR ? `REG_PC : instr.dst_reg] <= tmp;
            default:
               regs[`REG_PC] <= regs[`REG_PC];
         endcase
      end
   end

   // status flags; instructions never touch the mode bits, only a host write to sr does
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         sr <= `SR_RESET;
      end
      else if (!busy && wr_acc && paddr == `OFS_SR)
      begin
         sr <= pwdata[15:0];
      end
      else if (state == ST_IDLE && start && !mode_err &&
               (instr.op == wide_addr_pkg::OP_ADD_ADDRESS_WORD ||
                instr.op == wide_addr_pkg::OP_SUBTRACT_WIDE ||
                instr.op == wide_addr_pkg::OP_COMPARE_WIDE))
      begin
         sr[`SR_NEG_BIT]   <= res[19];
         sr[`SR_ZERO_BIT]  <= res == 20'h00000;
         sr[`SR_CARRY_BIT] <= sum[20];
         sr[`SR_OVF_BIT]   <= ovf;
      end
   end

   // instruction, source operand and index load registers
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         instr   <= '0;
         src_imm <= 20'h00000;
         index   <= 16'h0000;
      end
      else if (!busy && wr_acc)
      begin
         unique case (paddr)
            `OFS_INSTR: instr   <= wide_addr_pkg::instr_t'(pwdata[14:0]);
            `OFS_SRC:   src_imm <= pwdata[19:0];
            `OFS_INDEX: index   <= pwdata[15:0];
            default:    index   <= index;
         endcase
      end
   end

   // read data
   // captured in the setup cycle so it stands through the access phase
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         prdata <= 32'h00000000;
      end
      else if (psel && !penable)
      begin
         if (paddr >= `OFS_REG_BASE && paddr <= `OFS_REG_LAST)
            prdata <= {12'h000, regs[paddr[5:2]]};
         else
         begin
            unique case (paddr)
               `OFS_INSTR:  prdata <= {17'h00000, instr};
               `OFS_SRC:    prdata <= {12'h000, src_imm};
               `OFS_INDEX:  prdata <= {16'h0000, index};
               `OFS_STATUS: prdata <= {30'h00000000, mode_err, busy};
               `OFS_SR:     prdata <= {16'h0000, sr};
               `OFS_PC:     prdata <= {12'h000, regs[`REG_PC]};
               `OFS_SP:     prdata <= {12'h000, regs[`REG_SP]};
               default:     prdata <= 32'h00000000;
            endcase
         end
      end
   end
endmodule : wide_address_instruction_unit
`default_nettype wire

//--- verif/wide_addr_props.sv
`timescale 1ns/1ps
`include "wide_addr_cfg.svh"
`default_nettype none
module wide_addr_props (
   input wire logic                    sys_clk,
   input wire logic                    reset_n,
   input wire logic                    psel,
   input wire logic                    penable,
   input wire logic                    pwrite,
   input wire logic [11:0]             paddr,
   input wire logic [31:0]             pwdata,
   input wire logic [31:0]             prdata,
   input wire logic                    pready,
   input wire logic                    pslverr,
   input wire wide_addr_pkg::mem_req_t mem_req,
   input wire logic                    mem_ack,
   input wire logic [15:0]             mem_rdata
);
   logic [2:0] mode_keep;
   logic [1:0] wr_cnt;
   logic [1:0] rd_cnt;
   // software copy of the mode bits
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
         mode_keep <= 3'h0;
      else if (psel && penable && pwrite && paddr == `OFS_SR)
         mode_keep <= pwdata[5:3];
   end
   // words moved while the request stays up
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         wr_cnt <= 2'h0;
         rd_cnt <= 2'h0;
      end
      else if (!mem_req.req)
      begin
         wr_cnt <= 2'h0;
         rd_cnt <= 2'h0;
      end
      else if (mem_ack)
      begin
         wr_cnt <= wr_cnt + {1'b0, mem_req.we};
         rd_cnt <= rd_cnt + {1'b0, !mem_req.we};
      end
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   a_req_held: assert property (mem_req.req && !mem_ack |=> mem_req.req && $stable(mem_req))
      else $error("memory request changed before ack");
   a_read_ascend: assert property (mem_req.req && !mem_req.we && mem_ack |=>
      !(mem_req.req && !mem_req.we) || mem_req.addr == $past(mem_req.addr) + 20'h2)
      else $error("second read word not at address plus 2");
   a_push_descend: assert property (mem_req.req && mem_req.we && mem_ack |=>
      !(mem_req.req && mem_req.we) || mem_req.addr == $past(mem_req.addr) - 20'h2)
      else $error("second push not two below the first");
   a_push_high_first: assert property ($rose(mem_req.req && mem_req.we) |-> mem_req.wdata[15:4] == 12'h0)
      else $error("first push is not the high return bits");
   a_mode_bits_kept: assert property (psel && penable && !pwrite && paddr == `OFS_SR |->
      prdata[5:3] == mode_keep)
      else $error("mode bits changed");
   a_two_pushes: assert property (wr_cnt <= 2'h2)
      else $error("more than two stack words written");
   a_two_reads: assert property (rd_cnt <= 2'h2)
      else $error("more than two target words read");
   a_even_addr: assert property (mem_req.req |-> !mem_req.addr[0])
      else $error("memory word address is odd");
endmodule : wide_addr_props
bind wide_address_instruction_unit wide_addr_props u_props (.sys_clk(sys_clk), .reset_n(reset_n),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .mem_req(mem_req), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
`default_nettype wire

//--- verif/wide_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module wide_mem_model (
   input  wire logic                    sys_clk,
   input  wire logic                    reset_n,
   input  wire logic [3:0]              lat,
   input  wire wide_addr_pkg::mem_req_t mem_req,
   output logic                         mem_ack,
   output logic [15:0]                  mem_rdata
);
   logic [15:0] store [logic [19:0]];
   logic [3:0]  wait_cnt;
   // answers after lat idle cycles; read data is scrambled outside the ack cycle
   always @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         mem_ack <= 1'b0;
         wait_cnt <= 4'h0;
         mem_rdata <= 16'hA5A5;
      end
      else if (mem_ack)
      begin
         if (mem_req.we)
            store[mem_req.addr] = mem_req.wdata;
         mem_ack <= 1'b0;
         wait_cnt <= 4'h0;
         mem_rdata <= ~mem_rdata;
      end
      else if (mem_req.req && wait_cnt == lat)
      begin
         mem_ack <= 1'b1;
         mem_rdata <= store.exists(mem_req.addr) ? store[mem_req.addr] : 16'h5A5A;
      end
      else if (mem_req.req)
         wait_cnt <= wait_cnt + 4'h1;
   end
endmodule : wide_mem_model
`default_nettype wire

//--- verif/wide_address_instruction_unit_tb.sv
`timescale 1ns/1ps
`include "wide_addr_cfg.svh"
`default_nettype none
module wide_address_instruction_unit_tb;
   localparam logic [3:0]  op_mov = wide_addr_pkg::OP_MOVE_WIDE;
   localparam logic [3:0]  op_add = wide_addr_pkg::OP_ADD_ADDRESS_WORD;
   localparam logic [3:0]  op_sub = wide_addr_pkg::OP_SUBTRACT_WIDE;
   localparam logic [3:0]  op_cmp = wide_addr_pkg::OP_COMPARE_WIDE;
   localparam logic [31:0] sr0    = 32'h0000013D;
   logic                    sys_clk;
   logic                    reset_n;
   logic                    psel;
   logic                    penable;
   logic                    pwrite;
   logic [11:0]             paddr;
   logic [31:0]             pwdata;
   logic [31:0]             prdata;
   logic                    pready;
   logic                    pslverr;
   logic [3:0]              lat;
   logic                    mem_ack;
   logic [15:0]             mem_rdata;
   wide_addr_pkg::mem_req_t mem_req;
   int                      failures;
   int                      comparisons;
   logic [31:0]             rd;
   wide_address_instruction_unit dut (.sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .mem_req(mem_req), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
   wide_mem_model mem (.sys_clk(sys_clk), .reset_n(reset_n), .lat(lat), .mem_req(mem_req),
      .mem_ack(mem_ack), .mem_rdata(mem_rdata));
   initial
   begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   task give_verdict;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : give_verdict
   task check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         failures++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   function automatic logic [11:0] reg_at(input int n);
      return `OFS_REG_BASE + 12'(4 * n);
   endfunction : reg_at
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge sys_clk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
      if (n >= 20)
      begin
         failures++;
         give_verdict();
      end
   endtask : apb
   task run(input logic [3:0] op, input logic [2:0] md, input logic [3:0] s, input logic [3:0] d);
      int n;
      apb(1'b1, `OFS_INSTR, {17'h0, op, md, s, d});
      apb(1'b1, `OFS_CTRL, 32'h1);
      n = 0;
      do
      begin
         apb(1'b0, `OFS_STATUS, 32'h0);
         n++;
      end
      while (rd[0] !== 1'b0 && n < 100);
      if (n >= 100)
      begin
         failures++;
         give_verdict();
      end
   endtask : run
   task arith(input logic [3:0] op, input logic [2:0] md, input logic [19:0] d, input logic [19:0] s);
      logic [20:0] r;
      logic        v;
      logic [31:0] esr;
      logic [19:0] ed;
      r = (op == op_add) ? {1'b0, d} + {1'b0, s} : {1'b0, d} + {1'b0, ~s} + 21'h1;
      v = (r[19] ^ d[19]) & ((op == op_add) == (d[19] == s[19]));
      esr = {23'h0, v, 5'b00111, r[19], r[19:0] == 20'h0, r[20]};
      ed = (op == op_cmp) ? d : r[19:0];
      if (op == op_mov || md > 3'h1)
         esr = sr0;
      if (op == op_mov)
         ed = s;
      if (md > 3'h1)
         ed = d;
      apb(1'b1, reg_at(4), {12'h0, d});
      apb(1'b1, reg_at(5), {12'h0, s});
      apb(1'b1, `OFS_SRC, {12'h0, s});
      apb(1'b1, `OFS_SR, sr0);
      run(op, md, 4'h5, 4'h4);
      apb(1'b0, reg_at(4), 32'h0);
      check(rd, {12'h0, ed});
      apb(1'b0, `OFS_SR, 32'h0);
      check(rd, esr);
      apb(1'b0, reg_at(5), 32'h0);
      check(rd, {12'h0, s});
   endtask : arith
   task jump(input logic [2:0] md, input logic [19:0] r6, input logic [31:0] idx, input logic [19:0] x);
      mem.store[x] = 16'h1234;
      mem.store[x + 20'h2] = 16'h0005;
      apb(1'b1, reg_at(6), {12'h0, r6});
      apb(1'b1, `OFS_INDEX, idx);
      apb(1'b1, `OFS_SRC, {12'h0, x});
      apb(1'b1, `OFS_SR, sr0);
      run(op_mov, md, 4'h6, 4'h0);
      apb(1'b0, `OFS_PC, 32'h0);
      check(rd, 32'h00051234);
      apb(1'b0, `OFS_SR, 32'h0);
      check(rd, sr0);
      apb(1'b0, reg_at(6), 32'h0);
      check(rd, {12'h0, md == 3'h6 ? r6 + 20'h4 : r6});
   endtask : jump
   task call_return;
      apb(1'b1, `OFS_SP, 32'h400);
      apb(1'b1, `OFS_PC, 32'h12344);
      apb(1'b1, `OFS_SRC, 32'hABCE);
      apb(1'b1, `OFS_SR, sr0);
      run(wide_addr_pkg::OP_CALL_FAR, 3'h1, 4'h0, 4'h0);
      check({16'h0, mem.store[20'h003FE]}, 32'h1);
      check({16'h0, mem.store[20'h003FC]}, 32'h2344);
      apb(1'b0, `OFS_SP, 32'h0);
      check(rd, 32'h3FC);
      apb(1'b0, `OFS_PC, 32'h0);
      check(rd, 32'hABCE);
      apb(1'b0, `OFS_SR, 32'h0);
      check(rd, sr0);
      run(wide_addr_pkg::OP_RETURN_FAR, 3'h0, 4'h0, 4'h0);
      apb(1'b0, `OFS_PC, 32'h0);
      check(rd, 32'h12344);
      apb(1'b0, `OFS_SP, 32'h0);
      check(rd, 32'h400);
   endtask : call_return
   initial
   begin
      failures = 0;
      comparisons = 0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      lat = 4'h0;
      reset_n = 1'b0;
      repeat (16) @(posedge sys_clk);
      reset_n <= 1'b1;
      @(posedge sys_clk);
      arith(op_add, 3'h1, 20'hFFFFF, 20'h00001);
      arith(op_add, 3'h0, 20'h7FFFF, 20'h00001);
      arith(op_add, 3'h0, 20'h80000, 20'h80000);
      arith(op_add, 3'h2, 20'h00001, 20'h00001);
      arith(op_cmp, 3'h1, 20'h12345, 20'h12345);
      arith(op_cmp, 3'h0, 20'h00001, 20'h00002);
      arith(op_cmp, 3'h0, 20'h7FFFF, 20'h80000);
      arith(op_cmp, 3'h0, 20'h80000, 20'h00001);
      arith(op_sub, 3'h1, 20'h00002, 20'h00002);
      arith(op_sub, 3'h1, 20'h00001, 20'h00002);
      arith(op_sub, 3'h1, 20'h80000, 20'h00002);
      arith(op_add, 3'h1, 20'hFFFFE, 20'h00002);
      arith(op_add, 3'h1, 20'h7FFFE, 20'h00002);
      arith(op_add, 3'h1, 20'h7FFFF, 20'h00002);
      arith(op_mov, 3'h1, 20'h12345, 20'h00000);
      jump(3'h2, 20'h10004, 32'h0000FFFC, 20'h10000);
      lat <= 4'h3;
      jump(3'h4, 20'h00000, 32'h0, 20'h08000);
      jump(3'h6, 20'h0C000, 32'h0, 20'h0C000);
      jump(3'h5, 20'h0C000, 32'h0, 20'h0C000);
      jump(3'h3, 20'h0C000, 32'h00000DCC, 20'h52000);
      call_return();
      give_verdict();
   end
endmodule : wide_address_instruction_unit_tb
`default_nettype wire
